// ===== verilog/euar_defs.svh
`ifndef EUAR_DEFS_SVH
`define EUAR_DEFS_SVH
// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define EUAR_OFF_SDATA    8'h00
`define EUAR_OFF_SCTRL    8'h04
`define EUAR_OFF_PCTRL    8'h08
`define EUAR_OFF_SLAVE_ADDR_REG    8'h0c
`define EUAR_OFF_SMASK    8'h10
`define EUAR_OFF_TCTRL    8'h14
`define EUAR_OFF_RELOAD   8'h18
`define EUAR_OFF_STATUS   8'h1c
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EUAR_SC_MODE_HI   7
`define EUAR_SC_MODE_LO   6
`define EUAR_SC_MPROC     5
`define EUAR_SC_RXEN      4
`define EUAR_SC_TB8       3
`define EUAR_SC_RB8       2
`define EUAR_SC_TXDONE    1
`define EUAR_SC_RXDONE    0
`define EUAR_PC_FESEL     6
// ----------------------------------------------------------------
// reset values and timer baud codes
// ----------------------------------------------------------------
`define EUAR_SCTRL_RST    8'h00
`define EUAR_ADDR_RST     8'h00
`define EUAR_TCTRL_RST    8'h00
`define EUAR_RELOAD_RST   16'hfff0
`define EUAR_TC_BAUD_RXTX 8'h34
`define EUAR_TC_BAUD_RX   8'h24
`define EUAR_TC_BAUD_TX   8'h14
`define EUAR_TC_GATE      8'h02
// mode 0 shift clock divider in system clocks
`define EUAR_M0_DIV       16'd12
`endif

// ===== verilog/euar_pkg.sv
package euar_pkg;
    // serial frame modes selected by the two mode bits
    typedef enum logic [1:0] {
        EUAR_M0_SHIFT = 2'b00,
        EUAR_M1_8BIT  = 2'b01,
        EUAR_M2_9FIX  = 2'b10,
        EUAR_M3_9VAR  = 2'b11
    } euar_mode_t;
    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } euar_req_t;
endpackage

// ===== verilog/euar_uart.sv
`timescale 1ns/100ps
// How it works
// - one data address, write tx, read rx
// - four modes from two mode bits
// - any data buffer write starts transmit
// - mode 0 receive when flag clear, enabled
// - modes 1-3 receive on start bit if enabled
// - stop bit check when framing select set
// - missing stop bit sets framing error flag
// - framing error sticky until software clears
// - with check, receive flag at stop bit
// - multiproc 9-bit: flag only on address match
// - mode 1 multiproc: match plus valid stop
// - mode 0 ignores multiprocessor bit
// - given address: mask selects compared bits
// - timer codes select baud generator use
// - baud mode ignores trigger pin falls
// - broadcast is address or mask
// - address and mask reset to zero
`include "euar_defs.svh"
module euar_uart
    import euar_pkg::*;
#(
    parameter int OVERSAMPLE = 16    // bit time in baud ticks
) (
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire euar_req_t  i_req,
    output logic [7:0]      o_rdata,
    input  wire logic       i_rxd,
    output logic            o_txd,
    output logic            o_rxd_out,   // held high; mode 0 data goes out on o_txd
    output logic            o_rxd_oe_n,  // low while driving
    output logic            o_sclk,      // mode 0 receive shift clock; mode 0 transmit does not pulse it
    input  wire logic       i_trig,      // timer trigger pin
    output logic            o_trig_evt   // trigger capture pulse
);
    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    logic [7:0]  sctrl_reg;       // serial control
    logic        fesel_reg;       // framing check select
    logic        fe_reg;          // framing error flag
    logic [7:0]  slave_addr_reg_reg;       // slave address
    logic [7:0]  smask_reg;       // address mask
    logic [7:0]  tctrl_reg;       // timer control
    logic [15:0] reload_reg;      // baud reload value
    logic [7:0]  rxbuf_reg;       // receive register
    logic        trig_reg;        // trigger pin delayed
    euar_mode_t  mode;
    logic        wr_data;
    logic        rxdone_set;
    logic        txdone_set;
    logic        fe_set;
    logic        rb8_set;
    logic        rb8_val;
    assign mode    = euar_mode_t'(sctrl_reg[7:6]);
    assign wr_data = i_req.wr && i_req.addr == `EUAR_OFF_SDATA;

    // address match: given or broadcast, mask 0 bits don't-care
    function automatic logic addr_hit(input logic [7:0] b,
                                      input logic [7:0] a,
                                      input logic [7:0] m);
        logic [7:0] bc;
        bc = a | m;
        addr_hit = (((b ^ a) & m) == 8'h00) ||
                   (((b ^ 8'hff) & bc) == 8'h00);
    endfunction

    // ----------------------------------------------------------------
    // register writes, flags set over clear
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sctrl_reg <= `EUAR_SCTRL_RST;
        end else begin
            if (i_req.wr && i_req.addr == `EUAR_OFF_SCTRL) begin
                sctrl_reg <= i_req.wdata;
            end
            // hardware sets win over the software write
            if (rxdone_set) begin
                sctrl_reg[`EUAR_SC_RXDONE] <= 1'b1;
                sctrl_reg[`EUAR_SC_RB8]    <= rb8_val;
            end
            if (txdone_set) begin
                sctrl_reg[`EUAR_SC_TXDONE] <= 1'b1;
            end
        end
    end

    // framing select and sticky framing error share one register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fesel_reg <= 1'b0;
            fe_reg    <= 1'b0;
        end else begin
            if (i_req.wr && i_req.addr == `EUAR_OFF_PCTRL) begin
                fesel_reg <= i_req.wdata[`EUAR_PC_FESEL];
                fe_reg    <= i_req.wdata[0] & fe_reg;
            end
            // valid stops never clear it, errors set it
            if (fe_set) begin
                fe_reg <= 1'b1;
            end
        end
    end

    // address, mask and timer setup
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slave_addr_reg_reg  <= `EUAR_ADDR_RST;
            smask_reg  <= `EUAR_ADDR_RST;
            tctrl_reg  <= `EUAR_TCTRL_RST;
            reload_reg <= `EUAR_RELOAD_RST;
        end else if (i_req.wr) begin
            unique case (i_req.addr)
                `EUAR_OFF_SLAVE_ADDR_REG:  slave_addr_reg_reg  <= i_req.wdata;
                `EUAR_OFF_SMASK:  smask_reg  <= i_req.wdata;
                `EUAR_OFF_TCTRL:  tctrl_reg  <= i_req.wdata;
                `EUAR_OFF_RELOAD: reload_reg <= {8'h00, i_req.wdata};
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // baud generator from the general timer
    // ----------------------------------------------------------------
    logic [15:0] baud_cnt_reg;
    logic        baud_tick;
    logic        baud_mode;
    logic        rx_tick;
    logic        tx_tick;
    // gate bit folds the external-gated codes onto the plain ones
    assign baud_mode = (tctrl_reg & ~`EUAR_TC_GATE) inside
        {`EUAR_TC_BAUD_RXTX, `EUAR_TC_BAUD_RX, `EUAR_TC_BAUD_TX};
    assign baud_tick = baud_cnt_reg == 16'hffff;
    // a direction not served by a baud code gets no ticks; outside baud mode both use the timer
    assign rx_tick = (tctrl_reg[5] || !baud_mode) && baud_tick;
    assign tx_tick = (tctrl_reg[4] || !baud_mode) && baud_tick;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            baud_cnt_reg <= `EUAR_RELOAD_RST;
        end else if (baud_tick) begin
            baud_cnt_reg <= reload_reg;
        end else begin
            baud_cnt_reg <= baud_cnt_reg + 16'h0001;
        end
    end

    // trigger falls only capture outside baud mode
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            trig_reg   <= 1'b1;
            o_trig_evt <= 1'b0;
        end else begin
            trig_reg   <= i_trig;
            o_trig_evt <= trig_reg && !i_trig && tctrl_reg[3]
                          && !baud_mode;
        end
    end

    // ----------------------------------------------------------------
    // transmitter: shifts start, data, ninth bit (modes 2-3), stop; mode 0 shifts data only
    // ----------------------------------------------------------------
    logic [10:0] tx_sh_reg;
    logic [3:0]  tx_bits_reg;
    logic [3:0]  tx_os_reg;
    logic [15:0] m0_cnt_reg;
    logic        m0_edge;
    assign m0_edge = m0_cnt_reg == `EUAR_M0_DIV - 16'd1;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            m0_cnt_reg <= 16'h0000;
        end else begin
            m0_cnt_reg <= m0_edge ? 16'h0000 : m0_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_sh_reg   <= 11'h7ff;
            tx_bits_reg <= 4'h0;
            tx_os_reg   <= 4'h0;
            o_txd       <= 1'b1;
            txdone_set  <= 1'b0;
        end else begin
            txdone_set <= 1'b0;
            if (wr_data) begin
                // 9-bit modes carry the ninth bit before stop
                if (mode == EUAR_M0_SHIFT) begin
                    tx_sh_reg   <= {3'h7, i_req.wdata};
                    tx_bits_reg <= 4'd8;
                end else if (mode == EUAR_M1_8BIT) begin
                    tx_sh_reg   <= {2'h3, i_req.wdata, 1'b0};
                    tx_bits_reg <= 4'd10;
                end else begin
                    tx_sh_reg   <= {1'b1, sctrl_reg[`EUAR_SC_TB8],
                                    i_req.wdata, 1'b0};
                    tx_bits_reg <= 4'd11;
                end
                tx_os_reg <= 4'h0;
            end else if (tx_bits_reg != 4'h0) begin
                if (mode == EUAR_M0_SHIFT ? m0_edge : tx_tick) begin
                    tx_os_reg <= tx_os_reg + 4'h1;
                    if (mode == EUAR_M0_SHIFT ||
                        tx_os_reg == 4'(OVERSAMPLE - 1)) begin
                        o_txd       <= tx_sh_reg[0];
                        tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
                        tx_bits_reg <= tx_bits_reg - 4'h1;
                        tx_os_reg   <= 4'h0;
                        txdone_set  <= tx_bits_reg == 4'h1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // receiver: mode 0 shift in, modes 1-3 sampled mid-bit
    // ----------------------------------------------------------------
    logic [9:0]  rx_sh_reg;
    logic [3:0]  rx_bits_reg;
    logic [3:0]  rx_os_reg;
    logic [3:0]  rx_need;
    logic        rx_busy;
    logic        stop_ok;
    logic        accept;
    assign rx_busy = rx_bits_reg != 4'h0;
    assign rx_need = (mode == EUAR_M1_8BIT) ? 4'd9 : 4'd10;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_sh_reg   <= 10'h000;
            rx_bits_reg <= 4'h0;
            rx_os_reg   <= 4'h0;
            rxbuf_reg   <= 8'h00;
            rxdone_set  <= 1'b0;
            fe_set      <= 1'b0;
            rb8_val     <= 1'b0;
            o_sclk      <= 1'b1;
            o_rxd_out   <= 1'b1;
            o_rxd_oe_n  <= 1'b1;
        end else begin
            rxdone_set <= 1'b0;
            fe_set     <= 1'b0;
            if (!rx_busy) begin
                // shift clock rests high between mode 0 bytes
                o_rxd_oe_n <= 1'b1;
                o_sclk     <= 1'b1;
                if (mode == EUAR_M0_SHIFT) begin
                    if (sctrl_reg[`EUAR_SC_RXEN] &&
                        !sctrl_reg[`EUAR_SC_RXDONE]) begin
                        rx_bits_reg <= 4'd8;
                    end
                end else if (sctrl_reg[`EUAR_SC_RXEN] && !i_rxd) begin
                    rx_bits_reg <= rx_need + 4'h1;
                    rx_os_reg   <= 4'h0;
                end
            end else if (mode == EUAR_M0_SHIFT) begin
                // mode 0 samples data on every second divided clock edge, as the shift clock falls
                if (m0_edge) begin
                    o_sclk      <= !o_sclk;
                    if (o_sclk) begin
                        rx_sh_reg   <= {i_rxd, rx_sh_reg[9:1]};
                        rx_bits_reg <= rx_bits_reg - 4'h1;
                        if (rx_bits_reg == 4'h1) begin
                            // multiproc bit has no effect here
                            rxbuf_reg  <= {i_rxd, rx_sh_reg[9:3]};
                            rxdone_set <= 1'b1;
                            rb8_val    <= 1'b0;
                        end
                    end
                end
            end else if (rx_tick) begin
                // wrap at the bit time so short bit times stay aligned
                rx_os_reg <= (rx_os_reg == 4'(OVERSAMPLE - 1)) ? 4'h0 :
                             rx_os_reg + 4'h1;
                if (rx_os_reg == 4'(OVERSAMPLE / 2 - 1)) begin
                    rx_sh_reg   <= {i_rxd, rx_sh_reg[9:1]};
                    rx_bits_reg <= rx_bits_reg - 4'h1;
                    if (rx_bits_reg == 4'h1) begin
                        // stop bit sampled last, frame complete
                        rxbuf_reg  <= (mode == EUAR_M1_8BIT) ?
                                      rx_sh_reg[9:2] : rx_sh_reg[8:1];
                        rb8_val    <= !accept ? 1'b0 :
                                      (mode == EUAR_M1_8BIT) ? i_rxd :
                                      rx_sh_reg[9];
                        rxdone_set <= accept;
                        fe_set     <= fesel_reg && !i_rxd;
                    end
                end
            end
        end
    end

    // frame acceptance with stop in i_rxd and prior bits shifted in
    always_comb begin
        logic [7:0] byte_in;
        logic       ninth;
        byte_in = 8'h00;
        ninth   = 1'b0;
        stop_ok = i_rxd;
        if (mode == EUAR_M1_8BIT) begin
            byte_in = rx_sh_reg[9:2];
            ninth   = i_rxd;
        end else begin
            byte_in = rx_sh_reg[8:1];
            ninth   = rx_sh_reg[9];
        end
        if (sctrl_reg[`EUAR_SC_MPROC]) begin
            // address frames carry ninth bit high
            accept = ninth && addr_hit(byte_in, slave_addr_reg_reg, smask_reg)
                     && stop_ok;
        end else begin
            // flag rises on the stop sample with or without check
            accept = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else if (i_req.rd) begin
            unique case (i_req.addr)
                `EUAR_OFF_SDATA:  o_rdata <= rxbuf_reg;
                `EUAR_OFF_SCTRL:  o_rdata <= sctrl_reg;
                `EUAR_OFF_PCTRL:  o_rdata <= {1'b0, fesel_reg,
                                             5'h00, fe_reg};
                `EUAR_OFF_SLAVE_ADDR_REG:  o_rdata <= slave_addr_reg_reg;
                `EUAR_OFF_SMASK:  o_rdata <= smask_reg;
                `EUAR_OFF_TCTRL:  o_rdata <= tctrl_reg;
                `EUAR_OFF_RELOAD: o_rdata <= reload_reg[7:0];
                `EUAR_OFF_STATUS: o_rdata <= {6'h00, rx_busy,
                                             tx_bits_reg != 4'h0};
                default:          o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule

// ===== verification/euar_uart_assertions.sv
`timescale 1ns/100ps
// ------------------------------------------------
// port checker for the serial block
// ------------------------------------------------
`include "euar_defs.svh"
module euar_uart_chk
    import euar_pkg::*;
#(
    parameter int OVERSAMPLE = 16  // bit time in baud ticks
) (
    input wire logic       i_clk,
    input wire logic       i_arst_n,
    input wire euar_req_t  i_req,
    input wire logic [7:0] o_rdata,
    input wire logic       i_rxd,
    input wire logic       o_txd,
    input wire logic       o_rxd_out,
    input wire logic       o_rxd_oe_n,
    input wire logic       o_sclk,
    input wire logic       i_trig,
    input wire logic       o_trig_evt
);
    logic [7:0] sa_reg;  // shadow of the slave address
    logic [7:0] sm_reg;  // shadow of the mask
    logic [7:0] tc_reg;  // shadow of the timer control
    logic [1:0] md_reg;  // shadow of the mode bits
    logic       bd_tx;   // timer paces the transmitter
    logic       bd_any;  // timer in any baud use
    assign bd_tx  = (tc_reg & 8'hfd) == 8'h34 || (tc_reg & 8'hfd) == 8'h14;
    assign bd_any = bd_tx || (tc_reg & 8'hfd) == 8'h24;
    // shadows follow software writes only, flags are not needed
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sa_reg <= 8'h00;
            sm_reg <= 8'h00;
            tc_reg <= 8'h00;
            md_reg <= 2'h0;
        end else if (i_req.wr) begin
            case (i_req.addr)
                `EUAR_OFF_SLAVE_ADDR_REG: sa_reg <= i_req.wdata;
                `EUAR_OFF_SMASK: sm_reg <= i_req.wdata;
                `EUAR_OFF_TCTRL: tc_reg <= i_req.wdata;
                `EUAR_OFF_SCTRL: md_reg <= i_req.wdata[7:6];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_rdata_idle: assert property (
        !$past(i_req.rd) |-> o_rdata == 8'h00) else $error("stray rdata");
    a_addr_read: assert property (
        i_req.rd && i_req.addr == `EUAR_OFF_SLAVE_ADDR_REG |=> o_rdata == sa_reg)
        else $error("slave address readback wrong");
    a_mask_read: assert property (
        i_req.rd && i_req.addr == `EUAR_OFF_SMASK |=> o_rdata == sm_reg)
        else $error("mask readback wrong");
    a_tx_start: assert property (
        i_req.wr && i_req.addr == `EUAR_OFF_SDATA && bd_tx && md_reg != 0
        |-> ##[1:600] !o_txd) else $error("no start bit after write");
    a_start_hold: assert property (
        $fell(o_txd) |-> !o_txd [*8]) else $error("start bit too short");
    a_sclk_idle: assert property (
        md_reg != 2'b00 |-> o_sclk) else $error("shift clock outside mode 0");
    a_sclk_pulse: assert property (
        $fell(o_sclk) |-> ##[1:24] $rose(o_sclk)) else $error("sclk stuck");
    a_trig_quiet: assert property (
        bd_any |-> !o_trig_evt) else $error("trigger event in baud use");
endmodule
bind euar_uart euar_uart_chk #(.OVERSAMPLE(OVERSAMPLE)) chk_u (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req), .o_rdata(o_rdata),
    .i_rxd(i_rxd), .o_txd(o_txd), .o_rxd_out(o_rxd_out),
    .o_rxd_oe_n(o_rxd_oe_n), .o_sclk(o_sclk), .i_trig(i_trig),
    .o_trig_evt(o_trig_evt));

// ===== verification/euar_node.sv
`timescale 1ns/100ps
// ------------------------------------------------
// remote node on the shared serial line
// ------------------------------------------------
module euar_node #(
    parameter int BIT_CLK = 128  // clocks per bit
) (
    input  wire logic i_clk,
    input  wire logic i_line,  // what the block transmits
    output logic      o_line   // what the block receives, idle high
);
    initial o_line = 1'b1;
    // start, n data bits lsb first, stop; ninth is address flag
    task automatic send(input logic [8:0] d, input int n, input logic st);
        for (int i = 0; i < n + 2; i++) begin
            @(posedge i_clk);
            o_line <= (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : st;
            repeat (BIT_CLK - 1) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_line <= 1'b1;
    endtask
    // mid-bit sampling; a missing start times out after 4 bit times and reads the idle line
    task automatic recv(input int n, output logic [8:0] d, output logic st);
        int t;
        t = 0;
        d = 9'h000;
        while (i_line !== 1'b0 && t < 4 * BIT_CLK) begin
            @(posedge i_clk);
            t++;
        end
        repeat (BIT_CLK / 2) @(posedge i_clk);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CLK) @(posedge i_clk);
            d[i] = i_line;
        end
        repeat (BIT_CLK) @(posedge i_clk);
        st = i_line;
    endtask
endmodule

// ===== verification/euar_uart_test.sv
`timescale 1ns/100ps
`include "euar_defs.svh"
module euar_uart_test
    import euar_pkg::*;
;
    localparam int         OS   = 8;        // shortened bit time
    localparam int         BITC = OS * 16;  // default reload: 16 clocks a tick
    localparam logic [7:0] SA   = 8'hf1;    // slave address
    localparam logic [7:0] SM   = 8'hfa;    // mask
    localparam logic [7:0] TC[7] = '{8'h34, 8'h36, 8'h24, 8'h26, 8'h14,
                                     8'h16, 8'h08};
    localparam logic [8:0] AT[6] = '{9'h1f0, 9'h1f4, 9'h1f2, 9'h1fb,
                                     9'h1ff, 9'h0f1};
    logic       i_clk;
    logic       i_arst_n;
    logic       i_trig;
    logic       rxd;
    euar_req_t  i_req;
    logic [7:0] o_rdata;
    logic       o_txd;
    logic       o_sclk;
    logic       o_trig_evt;
    int         error_cnt;
    int         total_checks;
    euar_uart #(.OVERSAMPLE(OS)) dut_u (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(i_req),
        .o_rdata(o_rdata), .i_rxd(rxd), .o_txd(o_txd), .o_rxd_out(),
        .o_rxd_oe_n(), .o_sclk(o_sclk), .i_trig(i_trig),
        .o_trig_evt(o_trig_evt));
    euar_node #(.BIT_CLK(BITC)) node_u (
        .i_clk(i_clk), .i_line(o_txd), .o_line(rxd));
    always #2 i_clk = ~i_clk;
    // given address or broadcast (or of address and mask)
    function automatic logic hit(input logic [7:0] x);
        return ((x ^ SA) & SM) == 8'h00 || (x & (SA | SM)) == (SA | SM);
    endfunction
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
        @(posedge i_clk);
        i_req.wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [7:0] m,
                         input logic [7:0] e);
        @(posedge i_clk);
        i_req <= '{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00};
        @(posedge i_clk);
        i_req.rd <= 1'b0;
        #1 chk({1'b0, o_rdata & m}, {1'b0, e});
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge i_clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        logic [7:0] v;
        logic [8:0] e;
        logic [8:0] d;
        logic       s;
        logic       seen;
        i_clk = 1'b0;
        i_arst_n = 1'b0;
        i_trig = 1'b1;
        i_req = '0;
        error_cnt = 0;
        total_checks = 0;
        v = $urandom(44315);
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rdchk(`EUAR_OFF_SLAVE_ADDR_REG, 8'hff, 8'h00);
        rdchk(`EUAR_OFF_SMASK, 8'hff, 8'h00);
        rdchk(`EUAR_OFF_SCTRL, 8'hff, 8'h00);
        rdchk(8'h20, 8'hff, 8'h00);
        // trigger falls: only the plain reload code may react
        foreach (TC[i]) begin
            wr(`EUAR_OFF_TCTRL, TC[i]);
            seen = 1'b0;
            @(posedge i_clk) i_trig <= 1'b0;
            repeat (10) @(posedge i_clk) seen |= o_trig_evt;
            i_trig <= 1'b1;
            chk(seen, TC[i][3]);
        end
        wr(`EUAR_OFF_TCTRL, 8'h34);
        wr(`EUAR_OFF_SCTRL, 8'h50);
        // both directions at once through one data address
        repeat (4) begin
            v = $urandom;
            e = {1'b0, 8'($urandom)};
            fork
                wr(`EUAR_OFF_SDATA, v);
                node_u.recv(8, d, s);
                node_u.send(e, 8, 1'b1);
            join
            chk(d, {1'b0, v});
            chk(s, 1'b1);
            repeat (2 * BITC) @(posedge i_clk);
            rdchk(`EUAR_OFF_SDATA, 8'hff, e[7:0]);
            rdchk(`EUAR_OFF_SCTRL, 8'h03, 8'h03);
            wr(`EUAR_OFF_SCTRL, 8'h50);
        end
        wr(`EUAR_OFF_SCTRL, 8'h40);
        node_u.send(9'h0a5, 8, 1'b1);
        rdchk(`EUAR_OFF_SCTRL, 8'h01, 8'h00);
        // framing error is sticky past a good frame
        wr(`EUAR_OFF_PCTRL, 8'h40);
        wr(`EUAR_OFF_SCTRL, 8'h50);
        node_u.send(9'h03c, 8, 1'b0);
        rdchk(`EUAR_OFF_PCTRL, 8'h01, 8'h01);
        rdchk(`EUAR_OFF_SCTRL, 8'h01, 8'h01);
        // a low stop restarts the receiver; let that frame run out
        repeat (12 * BITC) @(posedge i_clk);
        node_u.send(9'h0c3, 8, 1'b1);
        rdchk(`EUAR_OFF_PCTRL, 8'h01, 8'h01);
        wr(`EUAR_OFF_PCTRL, 8'h40);
        rdchk(`EUAR_OFF_PCTRL, 8'h01, 8'h00);
        // address recognition, table then random
        wr(`EUAR_OFF_SLAVE_ADDR_REG, SA);
        wr(`EUAR_OFF_SMASK, SM);
        for (int i = 0; i < 10; i++) begin
            e = (i < 6) ? AT[i] : 9'($urandom);
            wr(`EUAR_OFF_SCTRL, 8'hf0);
            node_u.send(e, 9, 1'b1);
            rdchk(`EUAR_OFF_SCTRL, 8'h01, {7'h00, e[8] & hit(e[7:0])});
        end
        // mode 1: stop bit stands in for the ninth
        for (int i = 0; i < 2; i++) begin
            wr(`EUAR_OFF_SCTRL, 8'h70);
            node_u.send({1'b0, SA}, 8, 1'(i));
            rdchk(`EUAR_OFF_SCTRL, 8'h01, 8'(i));
            repeat (12 * BITC) @(posedge i_clk);
        end
        // mode 0 with the multiprocessor bit set still receives
        wr(`EUAR_OFF_SCTRL, 8'h30);
        v = 8'h00;
        for (int t = 0; t < 1000 && v[0] !== 1'b1; t++) begin
            @(posedge i_clk);
            i_req <= '{wr:1'b0, rd:1'b1, addr:`EUAR_OFF_SCTRL, wdata:8'h00};
            @(posedge i_clk);
            i_req.rd <= 1'b0;
            #1 v = o_rdata;
        end
        chk(v[0], 1'b1);
        rdchk(`EUAR_OFF_SDATA, 8'hff, 8'hff);
        give_verdict();
    end
endmodule
